// ===== common/sdp_pkg.sv
// Shared constants and types for the dual-port memory core.
package sdp_pkg;

	localparam int ADDR_W = 15;
	localparam int DATA_W = 36;
	localparam int LANES  = 4;
	localparam int LANE_W = 9;
	localparam int DEPTH  = 32768;
	localparam int PORTS  = 2;

	// Wishbone slave geometry
	localparam int WB_ADR_W = 8;
	localparam int WB_DAT_W = 32;

	// Register byte offsets
	localparam logic [WB_ADR_W-1:0] CTRL_OFS = 8'h00;
	localparam logic [WB_ADR_W-1:0] LCNT_OFS = 8'h04;
	localparam logic [WB_ADR_W-1:0] RCNT_OFS = 8'h08;
	localparam logic [WB_ADR_W-1:0] STAT_OFS = 8'h0C;

	// Field positions and reset values
	localparam int CTRL_EN_LSB   = 0;
	localparam int STAT_MODE_LSB = 0;
	localparam int STAT_DRV_LSB  = 2;
	localparam logic [PORTS-1:0] CTRL_EN_RST = 2'h3;

	// Output mode select levels
	localparam logic MODE_FLOW = 1'b0;
	localparam logic MODE_PIPE = 1'b1;

	// One port's sampled pin set
	typedef struct packed {
		logic [ADDR_W-1:0] addr_pins;
		logic              addr_strobe_n;
		logic              burst_advance_n;
		logic              burst_clear_n;
		logic              chip_en_n;
		logic              out_en_n;
		logic              rw_n;
		logic              flow_or_pipelined_sel;
		logic [LANES-1:0]  byte_lane_sel_n;
		logic [DATA_W-1:0] data_pins;
	} pins_t;

endpackage : sdp_pkg

// ===== rtl/port_engine.sv
// One memory port: pin sampling, burst counter, access issue, output stage.
`timescale 1ns/1ps

module port_engine (
	input  wire logic                        ref_clk,
	input  wire logic                        rst_n,
	input  wire logic                        port_en,
	input  wire logic                        clk_pin,
	input  wire logic [sdp_pkg::ADDR_W-1:0]  addr_pins,
	input  wire logic                        addr_strobe_n,
	input  wire logic                        burst_advance_n,
	input  wire logic                        burst_clear_n,
	input  wire logic                        chip_en_n,
	input  wire logic                        out_en_n,
	input  wire logic                        rw_n,
	input  wire logic                        flow_or_pipelined_sel,
	input  wire logic [sdp_pkg::LANES-1:0]   byte_lane_sel_n,
	input  wire logic [sdp_pkg::DATA_W-1:0]  data_in,
	input  wire logic [sdp_pkg::DATA_W-1:0]  mem_rdata,
	output logic      [sdp_pkg::ADDR_W-1:0]  acc_addr,
	output logic                             acc_we,
	output logic      [sdp_pkg::LANES-1:0]   acc_be,
	output logic      [sdp_pkg::DATA_W-1:0]  acc_wdata,
	output logic      [sdp_pkg::DATA_W-1:0]  data_out,
	output logic      [sdp_pkg::LANES-1:0]   data_oe_n,
	output logic      [sdp_pkg::ADDR_W-1:0]  burst_count,
	output logic                             mode_sel
);

	typedef struct packed {
		logic                       clk_s1;
		logic                       clk_s2;
		logic                       clk_prev;
		sdp_pkg::pins_t             pin_s1;
		sdp_pkg::pins_t             pin_s2;
		logic [sdp_pkg::ADDR_W-1:0] count;
		logic [sdp_pkg::ADDR_W-1:0] acc_addr;
		logic                       acc_we;
		logic                       acc_rd;
		logic [sdp_pkg::LANES-1:0]  acc_be;
		logic [sdp_pkg::DATA_W-1:0] acc_wdata;
		logic [sdp_pkg::DATA_W-1:0] rd_stage;
		logic [sdp_pkg::LANES-1:0]  stage_lanes;
		logic [sdp_pkg::DATA_W-1:0] dout;
		logic [sdp_pkg::LANES-1:0]  out_lanes;
		logic [sdp_pkg::LANES-1:0]  oe_n;
	} eng_state_t;

	eng_state_t s_reg;
	eng_state_t s_next;
	logic       port_edge;
	sdp_pkg::pins_t p;

	// Rising port clock, seen only after the second sync stage
	assign port_edge = port_en & s_reg.clk_s2 & ~s_reg.clk_prev;
	assign p         = s_reg.pin_s2;

	always_comb begin
		s_next = s_reg;
		// [R11] Two-stage pin sync
		s_next.clk_s1   = clk_pin;
		s_next.clk_s2   = s_reg.clk_s1;
		s_next.clk_prev = s_reg.clk_s2;
		s_next.pin_s1   = {addr_pins, addr_strobe_n, burst_advance_n, burst_clear_n, chip_en_n,
			out_en_n, rw_n, flow_or_pipelined_sel, byte_lane_sel_n, data_in};
		s_next.pin_s2   = s_reg.pin_s1;
		s_next.acc_we   = 1'b0;
		s_next.acc_rd   = 1'b0;
		// [R9] Flow-through shows data as soon as the array answers
		if (s_reg.acc_rd) begin
			s_next.rd_stage    = mem_rdata;
			s_next.stage_lanes = s_reg.acc_be;
			if (p.flow_or_pipelined_sel == sdp_pkg::MODE_FLOW) begin
				s_next.dout      = mem_rdata;
				s_next.out_lanes = s_reg.acc_be;
			end
		end
		if (port_edge) begin
			// [R3] Clear beats load and advance
			if (!p.burst_clear_n) begin
				s_next.count = '0;
			// [R2] Load needs strobe and advance low
			end else if (!p.addr_strobe_n && !p.burst_advance_n) begin
				s_next.count = p.addr_pins;
			// [R6] Advance by one
			end else if (!p.burst_advance_n) begin
				s_next.count = sdp_pkg::ADDR_W'(s_reg.count + 1'b1);
			end
			// [R9] Pipelined output moves one port clock later
			if (p.flow_or_pipelined_sel == sdp_pkg::MODE_PIPE) begin
				s_next.dout      = s_reg.rd_stage;
				s_next.out_lanes = s_reg.stage_lanes;
			end else begin
				s_next.out_lanes = '0;
			end
			s_next.stage_lanes = '0;
			if (!p.chip_en_n) begin
				// [R4] Strobe ignored while clearing
				s_next.acc_addr  = (p.burst_clear_n && !p.addr_strobe_n) ? p.addr_pins : s_reg.count;
				// [R10] Only selected lanes take part
				s_next.acc_be    = ~p.byte_lane_sel_n;
				s_next.acc_wdata = p.data_pins;
				// [R8] Low writes, high reads
				s_next.acc_we    = ~p.rw_n;
				s_next.acc_rd    = p.rw_n;
			end
		end
		if (!port_en) begin
			s_next.out_lanes = '0;
		end
		// [R7] Drive only lanes holding read data while enabled
		s_next.oe_n = ~(s_next.out_lanes & {sdp_pkg::LANES{~p.out_en_n}});
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_reg      <= '0;
			s_reg.oe_n <= '1;
		end else begin
			s_reg <= s_next;
		end
	end

	assign acc_addr    = s_reg.acc_addr;
	assign acc_we      = s_reg.acc_we;
	assign acc_be      = s_reg.acc_be;
	assign acc_wdata   = s_reg.acc_wdata;
	assign data_out    = s_reg.dout;
	assign data_oe_n   = s_reg.oe_n;
	assign burst_count = s_reg.count;
	assign mode_sel    = p.flow_or_pipelined_sel;

	// [R2] Load check
	a_load_addr: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R2]
		port_edge && p.burst_clear_n && !p.addr_strobe_n && !p.burst_advance_n
		|=> s_reg.count == $past(p.addr_pins)) else $error("address not loaded");
	// [R3] Clear check
	a_clear_wins: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R3]
		port_edge && !p.burst_clear_n |=> s_reg.count == '0) else $error("counter not cleared");
	// [R5] No advance under clear
	a_no_adv_clear: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R5]
		port_edge && !p.burst_clear_n && !p.burst_advance_n && s_reg.count != '1
		|=> s_reg.count != sdp_pkg::ADDR_W'($past(s_reg.count) + 1'b1)) else $error("advanced during clear");
	// [R6] Increment check
	a_count_incr: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R6]
		port_edge && p.burst_clear_n && p.addr_strobe_n && !p.burst_advance_n
		|=> s_reg.count == sdp_pkg::ADDR_W'($past(s_reg.count) + 1'b1)) else $error("no increment");
	// [R7] Output enable gate
	a_oe_gate: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R7]
		p.out_en_n |=> &s_reg.oe_n) else $error("driving with output disabled");
	// [R8] Direction check
	a_write_dir: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R8]
		s_reg.acc_we |-> !$past(p.rw_n) && !s_reg.acc_rd) else $error("write without low rw");
	// [R9] Flow data timing
	a_flow_data: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R9]
		s_reg.acc_rd && p.flow_or_pipelined_sel == sdp_pkg::MODE_FLOW
		|=> s_reg.dout == $past(mem_rdata)) else $error("flow data late");

endmodule : port_engine

// ===== rtl/dual_port_core.sv
// Dual-port memory core: shared array, two port engines and a Wishbone control slave.
//
// Local design decisions: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps

// Contract
// [R1] The host pulls the address strobe low so the access uses the address on the address pins.
// [R2] The counter loads the pin address only at a port clock rise with strobe and advance both low.
// [R3] A low counter clear zeroes that port's counter whatever strobe and advance do.
// [R4] While the counter clear is low the address strobe is ignored and nothing loads.
// [R5] While the counter clear is low the advance input is ignored and nothing counts.
// [R6] Each port clock rise with advance low, strobe high and clear high adds one to that port's counter.
// [R7] Data pins are driven for a read only while output enable is low, else released.
// [R8] Read/write low writes the shared array and high reads it.
// [R9] Mode select low gives flow-through output, high gives pipelined output.
// [R10] On the left port only bytes whose byte selects are low are read or written.
// [R11] The host may run each port clock free or in bursts but within the rate limit.
// [R12] Both ports run independently on their own clocks over one shared array.
module dual_port_core (
	input  wire logic                          ref_clk,
	input  wire logic                          rst_n,
	input  wire logic                          wb_cyc_i,
	input  wire logic                          wb_stb_i,
	input  wire logic                          wb_we_i,
	input  wire logic [sdp_pkg::WB_ADR_W-1:0]  wb_adr_i,
	input  wire logic [3:0]                    wb_sel_i,
	input  wire logic [sdp_pkg::WB_DAT_W-1:0]  wb_dat_i,
	output logic      [sdp_pkg::WB_DAT_W-1:0]  wb_dat_o,
	output logic                               wb_ack_o,
	input  wire logic                          left_clk_pin,
	input  wire logic [sdp_pkg::ADDR_W-1:0]    left_addr_pins,
	input  wire logic                          left_addr_strobe_n,
	input  wire logic                          left_burst_advance_n,
	input  wire logic                          left_burst_clear_n,
	input  wire logic                          left_chip_en_n,
	input  wire logic                          left_out_en_n,
	input  wire logic                          left_rw_n,
	input  wire logic                          left_flow_or_pipelined_sel,
	input  wire logic [sdp_pkg::LANES-1:0]     left_byte_lane_sel_n,
	input  wire logic [sdp_pkg::DATA_W-1:0]    left_data_in,
	output logic      [sdp_pkg::DATA_W-1:0]    left_data_out,
	output logic      [sdp_pkg::LANES-1:0]     left_data_oe_n,
	input  wire logic                          right_clk_pin,
	input  wire logic [sdp_pkg::ADDR_W-1:0]    right_addr_pins,
	input  wire logic                          right_addr_strobe_n,
	input  wire logic                          right_burst_advance_n,
	input  wire logic                          right_burst_clear_n,
	input  wire logic                          right_chip_en_n,
	input  wire logic                          right_out_en_n,
	input  wire logic                          right_rw_n,
	input  wire logic                          right_flow_or_pipelined_sel,
	input  wire logic [sdp_pkg::DATA_W-1:0]    right_data_in,
	output logic      [sdp_pkg::DATA_W-1:0]    right_data_out,
	output logic      [sdp_pkg::LANES-1:0]     right_data_oe_n
);

	localparam int AW = sdp_pkg::ADDR_W;
	localparam int DW = sdp_pkg::DATA_W;
	localparam int NL = sdp_pkg::LANES;
	localparam int LW = sdp_pkg::LANE_W;
	localparam int NP = sdp_pkg::PORTS;

	// Bus slave state
	typedef struct packed {
		logic                         ack;
		logic [sdp_pkg::WB_DAT_W-1:0] dat;
		logic [NP-1:0]                en;
	} wb_state_t;

	wb_state_t s_reg;
	wb_state_t s_next;

	// Shared storage, no reset: contents are undefined until written
	logic [DW-1:0] mem [sdp_pkg::DEPTH];

	// Per-port pin bundles, index 0 left and 1 right
	logic [NP-1:0]         clk_a;
	logic [AW-1:0]         addr_a  [NP];
	logic [NP-1:0]         ads_a;
	logic [NP-1:0]         adv_a;
	logic [NP-1:0]         clr_a;
	logic [NP-1:0]         ce_a;
	logic [NP-1:0]         oe_a;
	logic [NP-1:0]         rw_a;
	logic [NP-1:0]         mode_in_a;
	logic [NL-1:0]         be_a    [NP];
	logic [DW-1:0]         din_a   [NP];

	// Per-port engine results
	logic [AW-1:0]         acc_addr_a [NP];
	logic [NP-1:0]         acc_we_a;
	logic [NL-1:0]         acc_be_a   [NP];
	logic [DW-1:0]         acc_wd_a   [NP];
	logic [DW-1:0]         rdata_a    [NP];
	logic [DW-1:0]         mask_a     [NP];
	logic [DW-1:0]         dout_a     [NP];
	logic [NL-1:0]         oe_n_a     [NP];
	logic [AW-1:0]         cnt_a      [NP];
	logic [NP-1:0]         mode_a;

	// Gather left pins
	assign clk_a[0]     = left_clk_pin;
	assign addr_a[0]    = left_addr_pins;
	assign ads_a[0]     = left_addr_strobe_n;
	assign adv_a[0]     = left_burst_advance_n;
	assign clr_a[0]     = left_burst_clear_n;
	assign ce_a[0]      = left_chip_en_n;
	assign oe_a[0]      = left_out_en_n;
	assign rw_a[0]      = left_rw_n;
	assign mode_in_a[0] = left_flow_or_pipelined_sel;
	assign be_a[0]      = left_byte_lane_sel_n;
	assign din_a[0]     = left_data_in;

	// Gather right pins; the right port has no byte selects, so all lanes are on
	assign clk_a[1]     = right_clk_pin;
	assign addr_a[1]    = right_addr_pins;
	assign ads_a[1]     = right_addr_strobe_n;
	assign adv_a[1]     = right_burst_advance_n;
	assign clr_a[1]     = right_burst_clear_n;
	assign ce_a[1]      = right_chip_en_n;
	assign oe_a[1]      = right_out_en_n;
	assign rw_a[1]      = right_rw_n;
	assign mode_in_a[1] = right_flow_or_pipelined_sel;
	assign be_a[1]      = {NL{1'b0}};
	assign din_a[1]     = right_data_in;

	// Engine outputs are flops inside the engine
	assign left_data_out   = dout_a[0];
	assign left_data_oe_n  = oe_n_a[0];
	assign right_data_out  = dout_a[1];
	assign right_data_oe_n = oe_n_a[1];

	// [R12] One engine per port, each on its own sampled clock
	for (genvar i = 0; i < NP; i++) begin : g_port
		port_engine u_eng (
			.ref_clk               (ref_clk),
			.rst_n                 (rst_n),
			.port_en               (s_reg.en[i]),
			.clk_pin               (clk_a[i]),
			.addr_pins             (addr_a[i]),
			.addr_strobe_n         (ads_a[i]),
			.burst_advance_n       (adv_a[i]),
			.burst_clear_n         (clr_a[i]),
			.chip_en_n             (ce_a[i]),
			.out_en_n              (oe_a[i]),
			.rw_n                  (rw_a[i]),
			.flow_or_pipelined_sel (mode_in_a[i]),
			.byte_lane_sel_n       (be_a[i]),
			.data_in               (din_a[i]),
			.mem_rdata             (rdata_a[i]),
			.acc_addr              (acc_addr_a[i]),
			.acc_we                (acc_we_a[i]),
			.acc_be                (acc_be_a[i]),
			.acc_wdata             (acc_wd_a[i]),
			.data_out              (dout_a[i]),
			.data_oe_n             (oe_n_a[i]),
			.burst_count           (cnt_a[i]),
			.mode_sel              (mode_a[i])
		);

		// Asynchronous read of the word the port addresses
		assign rdata_a[i] = mem[acc_addr_a[i]];

		// Lane enables widened to the data width
		for (genvar l = 0; l < NL; l++) begin : g_lane
			assign mask_a[i][l*LW +: LW] = {LW{acc_be_a[i][l]}};
		end

		// [R10] Selected lanes take the new data
		a_lane_write: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R10]
			acc_we_a[i] && !(acc_we_a[1-i] && acc_addr_a[1-i] == acc_addr_a[i] && i == 0)
			|=> ((mem[$past(acc_addr_a[i])] ^ $past(acc_wd_a[i])) & $past(mask_a[i])) == '0)
			else $error("selected lane not written");

		// [R10] Unselected lanes keep old data
		a_lane_keep: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R10]
			acc_we_a[i] && !acc_we_a[1-i]
			|=> ((mem[$past(acc_addr_a[i])] ^ $past(rdata_a[i])) & ~$past(mask_a[i])) == '0)
			else $error("unselected lane changed");

		// [R12] A disabled port holds its counter
		a_port_hold: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R12]
			!s_reg.en[i] && $past(!s_reg.en[i]) |=> $stable(cnt_a[i]))
			else $error("disabled port moved");
	end

	// [R8] Array write; right port wins a same-word collision
	always_ff @(posedge ref_clk) begin
		for (int p = 0; p < NP; p++) begin
			for (int l = 0; l < NL; l++) begin
				// [R10] Lane masking on write
				if (acc_we_a[p] && acc_be_a[p][l]) begin
					mem[acc_addr_a[p]][l*LW +: LW] <= acc_wd_a[p][l*LW +: LW];
				end
			end
		end
	end

	// Wishbone decode: answer one cycle after the request is seen
	always_comb begin
		s_next     = s_reg;
		s_next.ack = 1'b0;
		if (wb_cyc_i && wb_stb_i && !s_reg.ack) begin
			s_next.ack = 1'b1;
			s_next.dat = '0;
			case (wb_adr_i)
				sdp_pkg::CTRL_OFS: begin
					s_next.dat[sdp_pkg::CTRL_EN_LSB +: NP] = s_reg.en;
					if (wb_we_i && wb_sel_i[0]) begin
						s_next.en = wb_dat_i[sdp_pkg::CTRL_EN_LSB +: NP];
					end
				end
				sdp_pkg::LCNT_OFS: begin
					s_next.dat[AW-1:0] = cnt_a[0];
				end
				sdp_pkg::RCNT_OFS: begin
					s_next.dat[AW-1:0] = cnt_a[1];
				end
				sdp_pkg::STAT_OFS: begin
					s_next.dat[sdp_pkg::STAT_MODE_LSB +: NP] = mode_a;
					s_next.dat[sdp_pkg::STAT_DRV_LSB]        = ~&oe_n_a[0];
					s_next.dat[sdp_pkg::STAT_DRV_LSB + 1]    = ~&oe_n_a[1];
				end
				default: begin
					s_next.dat = '0;
				end
			endcase
		end
	end

	// Both ports come up enabled so pins work without software
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_reg     <= '0;
			s_reg.en  <= sdp_pkg::CTRL_EN_RST;
		end else begin
			s_reg <= s_next;
		end
	end

	assign wb_ack_o = s_reg.ack;
	assign wb_dat_o = s_reg.dat;

	// Ack is a single pulse per request
	a_ack_pulse: assert property (@(posedge ref_clk) disable iff (!rst_n)
		wb_ack_o |=> !wb_ack_o) else $error("ack held");

	// Ack follows a fresh request by one edge
	a_ack_timing: assert property (@(posedge ref_clk) disable iff (!rst_n)
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");

	// Control write lands with its ack
	a_ctrl_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
		wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0] && wb_adr_i == sdp_pkg::CTRL_OFS
		|=> s_reg.en == $past(wb_dat_i[sdp_pkg::CTRL_EN_LSB +: NP])) else $error("ctrl not written");

	// Unmapped reads answer zero
	a_unmapped_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
		wb_cyc_i && wb_stb_i && !wb_ack_o && wb_adr_i[1:0] != 2'h0
		|=> wb_ack_o && wb_dat_o == '0) else $error("unmapped not zero");

	// Counter readback matches the left engine
	a_count_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
		wb_cyc_i && wb_stb_i && !wb_ack_o && wb_adr_i == sdp_pkg::LCNT_OFS
		|=> wb_dat_o[AW-1:0] == $past(cnt_a[0])) else $error("count readback wrong");

	// [R10] Right port writes whole words
	a_right_lanes: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R10]
		acc_we_a[1] |-> &acc_be_a[1]) else $error("right write not full word");

	// [R7] Disabled port lets go of its lanes
	a_dis_release: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R7]
		!s_reg.en[1] |=> &right_data_oe_n) else $error("disabled right port driving");

	// Stray writes leave the enables alone
	a_ctrl_keep: assert property (@(posedge ref_clk) disable iff (!rst_n)
		wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i != sdp_pkg::CTRL_OFS
		|=> $stable(s_reg.en)) else $error("enables changed by stray write");

	// [R9] Status shows sampled mode pins
	a_stat_mode: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R9]
		wb_cyc_i && wb_stb_i && !wb_ack_o && wb_adr_i == sdp_pkg::STAT_OFS
		|=> wb_dat_o[sdp_pkg::STAT_MODE_LSB +: NP] == $past(mode_a)) else $error("status mode wrong");

	// Read data stands until the next request
	a_dat_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!(wb_cyc_i && wb_stb_i && !wb_ack_o) |=> $stable(wb_dat_o)) else $error("read data moved");

	// No ack without a request behind it
	a_ack_cause: assert property (@(posedge ref_clk) disable iff (!rst_n)
		wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");

	// Right counter readback
	a_rcnt_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
		wb_cyc_i && wb_stb_i && !wb_ack_o && wb_adr_i == sdp_pkg::RCNT_OFS
		|=> wb_dat_o[AW-1:0] == $past(cnt_a[1])) else $error("right count wrong");

endmodule : dual_port_core

// ===== testbench/port_host.sv
// Host model that clocks one memory port in bursts and resolves its data wires.
`timescale 1ns/1ps

module port_host (
	input  wire logic        ref_clk,
	input  wire logic [35:0] data_out,
	input  wire logic [3:0]  data_oe_n,
	output logic             clk_pin,
	output logic      [14:0] addr_pins,
	output logic             burst_clear_n,
	output logic             addr_strobe_n,
	output logic             burst_advance_n,
	output logic             chip_en_n,
	output logic             out_en_n,
	output logic             rw_n,
	output logic             mode_sel,
	output logic      [3:0]  lanes_n,
	output logic      [35:0] data_in
);
	logic [35:0] drv;
	logic [35:0] last;
	logic        host_oe;

	// Idle: controls inactive and the port clock standing low
	initial begin
		{burst_clear_n, addr_strobe_n, burst_advance_n, chip_en_n, out_en_n, rw_n, mode_sel} = 7'h7E;
		clk_pin = 1'b0;
		addr_pins = 15'h0;
		lanes_n = 4'hF;
		drv = 36'h0;
		host_oe = 1'b0;
		last = 36'h0;
	end

	// Wire level per lane; a lane nobody drives toggles so stale data never passes
	always_comb begin
		for (int l = 0; l < 4; l++) begin
			data_in[9*l +: 9] = !data_oe_n[l] ? data_out[9*l +: 9] : host_oe ? drv[9*l +: 9] : ~last[9*l +: 9];
		end
	end

	always @(posedge ref_clk) last <= data_in;

	// Controls held around one burst clock rise
	task automatic op(input logic [6:0] c, input logic [3:0] ln, input logic [14:0] a, input logic [35:0] d);
		@(posedge ref_clk);
		{burst_clear_n, addr_strobe_n, burst_advance_n, chip_en_n, out_en_n, rw_n, mode_sel} <= c;
		lanes_n <= ln;
		addr_pins <= a;
		drv <= d;
		host_oe <= !c[1];
		repeat (4) @(posedge ref_clk);
		clk_pin <= 1'b1;
		repeat (4) @(posedge ref_clk);
		clk_pin <= 1'b0;
		repeat (3) @(posedge ref_clk);
	endtask : op
endmodule : port_host

// ===== testbench/dual_port_core_tb_top.sv
// Self-checking bench for the dual-port memory core.
`timescale 1ns/1ps

module dual_port_core_tb_top;
	// Control codes {clear, strobe, advance, chip, output, rw, mode}
	localparam logic [6:0] CLR = 7'h0E, LOAD = 7'h4E, ADV = 7'h6E, STB = 7'h5E, IDLE = 7'h7E;
	localparam logic [6:0] WR = 7'h54, RDF = 7'h52, RDX = 7'h56, RDP = 7'h53, NOPP = 7'h7B;
	logic        ref_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [7:0]  wb_adr_i;
	logic [3:0]  wb_sel_i, left_byte_lane_sel_n, left_data_oe_n, right_data_oe_n, prev_oe;
	logic [31:0] wb_dat_i, wb_dat_o, seed, r;
	logic        left_clk_pin, left_addr_strobe_n, left_burst_advance_n, left_burst_clear_n, left_chip_en_n;
	logic        left_out_en_n, left_rw_n, left_flow_or_pipelined_sel, right_clk_pin, right_addr_strobe_n;
	logic        right_burst_advance_n, right_burst_clear_n, right_chip_en_n, right_out_en_n, right_rw_n;
	logic        right_flow_or_pipelined_sel;
	logic [14:0] left_addr_pins, right_addr_pins, a, b;
	logic [35:0] left_data_in, left_data_out, right_data_in, right_data_out, d1, d2, e;
	logic [32:0] wq[$];
	logic [39:0] pq[$];
	logic [32:0] wn;
	logic [39:0] pn;
	int          num_errors, checks_done, cycles;

	dual_port_core dut_u (.ref_clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
		.wb_dat_o, .wb_ack_o, .left_clk_pin, .left_addr_pins, .left_addr_strobe_n, .left_burst_advance_n,
		.left_burst_clear_n, .left_chip_en_n, .left_out_en_n, .left_rw_n, .left_flow_or_pipelined_sel,
		.left_byte_lane_sel_n, .left_data_in, .left_data_out, .left_data_oe_n, .right_clk_pin, .right_addr_pins,
		.right_addr_strobe_n, .right_burst_advance_n, .right_burst_clear_n, .right_chip_en_n, .right_out_en_n,
		.right_rw_n, .right_flow_or_pipelined_sel, .right_data_in, .right_data_out, .right_data_oe_n);
	port_host left_h (.ref_clk, .data_out(left_data_out), .data_oe_n(left_data_oe_n), .clk_pin(left_clk_pin),
		.addr_pins(left_addr_pins), .burst_clear_n(left_burst_clear_n), .addr_strobe_n(left_addr_strobe_n),
		.burst_advance_n(left_burst_advance_n), .chip_en_n(left_chip_en_n), .out_en_n(left_out_en_n),
		.rw_n(left_rw_n), .mode_sel(left_flow_or_pipelined_sel), .lanes_n(left_byte_lane_sel_n),
		.data_in(left_data_in));
	// Right port has no lane selects: all lanes always
	port_host right_h (.ref_clk, .data_out(right_data_out), .data_oe_n(right_data_oe_n), .clk_pin(right_clk_pin),
		.addr_pins(right_addr_pins), .burst_clear_n(right_burst_clear_n), .addr_strobe_n(right_addr_strobe_n),
		.burst_advance_n(right_burst_advance_n), .chip_en_n(right_chip_en_n), .out_en_n(right_out_en_n),
		.rw_n(right_rw_n), .mode_sel(right_flow_or_pipelined_sel), .lanes_n(), .data_in(right_data_in));

	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	task automatic results;
		if (num_errors == 0 && checks_done > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : results

	task automatic cmp(input string what, input logic [35:0] exp, input logic [35:0] got);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	function automatic logic [35:0] mask(input logic [3:0] oe);
		for (int l = 0; l < 4; l++) mask[9*l +: 9] = {9{!oe[l]}};
	endfunction : mask

	// Classic single cycle; the note is queued before the answer can come
	task automatic wb(input logic we, input logic [7:0] ad, input logic [31:0] d, input logic [31:0] ex);
		@(posedge ref_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= ad;
		wb_dat_i <= d;
		wq.push_back({!we, ex});
		do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask : wb

	// Hang guard well above the whole sequence
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			num_errors++;
			results();
		end
	end

	// Each ack takes the oldest bus note
	always @(posedge ref_clk) if (wb_ack_o === 1'b1 && wq.size() > 0) begin
		wn = wq.pop_front();
		if (wn[32]) cmp("wb_dat_o", {4'h0, wn[31:0]}, {4'h0, wb_dat_o});
	end

	// A new driven lane set marks a read result; one nobody noted is a fault
	always @(posedge ref_clk) begin
		prev_oe <= left_data_oe_n;
		if (rst_n && left_data_oe_n !== prev_oe && left_data_oe_n !== 4'hF) begin
			if (pq.size() == 0) cmp("left_data_oe_n", 36'hF, {32'h0, left_data_oe_n});
			else begin
				pn = pq.pop_front();
				cmp("left_data_oe_n", {32'h0, pn[39:36]}, {32'h0, left_data_oe_n});
				cmp("left_data_out", pn[35:0] & mask(pn[39:36]), left_data_out & mask(pn[39:36]));
			end
		end
	end

	initial begin
		{rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = 'h0;
		wb_sel_i = 4'hF;
		prev_oe = 4'hF;
		seed = 32'hBABF;
		{num_errors, checks_done, cycles} = 'h0;
		repeat (5) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge ref_clk);
		wb(1'b0, sdp_pkg::CTRL_OFS, 32'h0, 32'h3);
		wb(1'b1, 8'h11, 32'hFFFFFFFF, 32'h0);
		wb(1'b0, 8'h10, 32'h0, 32'h0);
		r = rnd();
		a = r[14:0];
		b = a + 15'h1;
		left_h.op(LOAD, 4'h0, a, 36'h0);
		wb(1'b0, sdp_pkg::LCNT_OFS, 32'h0, {17'h0, a});
		left_h.op(ADV, 4'h0, ~a, 36'h0);
		wb(1'b0, sdp_pkg::LCNT_OFS, 32'h0, {17'h0, b});
		left_h.op(STB, 4'h0, ~a, 36'h0);
		wb(1'b0, sdp_pkg::LCNT_OFS, 32'h0, {17'h0, b});
		left_h.op(CLR, 4'h0, ~a, 36'h0);
		wb(1'b0, sdp_pkg::LCNT_OFS, 32'h0, 32'h0);
		r = rnd();
		d1 = {r[3:0], rnd()};
		d2 = {r[7:4], rnd()};
		e = {d1[35:27], d2[26:18], d1[17:9], d2[8:0]};
		left_h.op(WR, 4'h0, a, d1);
		left_h.op(WR, 4'hA, a, d2);
		pq.push_back({4'h0, e});
		left_h.op(RDF, 4'h0, a, 36'h0);
		pq.push_back({4'h6, e});
		left_h.op(RDF, 4'h6, a, 36'h0);
		left_h.op(RDX, 4'h0, a, 36'h0);
		left_h.op(IDLE, 4'h0, a, 36'h0);
		pq.push_back({4'h0, e});
		left_h.op(RDP, 4'h0, a, 36'h0);
		cmp("left_data_oe_n", 36'hF, {32'h0, left_data_oe_n});
		left_h.op(NOPP, 4'h0, a, 36'h0);
		wb(1'b0, sdp_pkg::STAT_OFS, 32'h0, 32'h5);
		right_h.op(WR, 4'h0, ~a, d2);
		right_h.op(RDF, 4'h0, ~a, 36'h0);
		cmp("right_data_out", d2, right_data_out);
		cmp("right_data_oe_n", 36'h0, {32'h0, right_data_oe_n});
		left_h.op(IDLE, 4'h0, a, 36'h0);
		pq.push_back({4'h0, d2});
		left_h.op(RDF, 4'h0, ~a, 36'h0);
		wb(1'b1, sdp_pkg::CTRL_OFS, 32'h1, 32'h0);
		right_h.op(LOAD, 4'h0, a, 36'h0);
		wb(1'b0, sdp_pkg::RCNT_OFS, 32'h0, 32'h0);
		wb(1'b0, sdp_pkg::CTRL_OFS, 32'h0, 32'h1);
		wb(1'b1, sdp_pkg::CTRL_OFS, 32'h3, 32'h0);
		right_h.op(LOAD, 4'h0, a, 36'h0);
		wb(1'b0, sdp_pkg::RCNT_OFS, 32'h0, {17'h0, a});
		repeat (4) @(posedge ref_clk);
		if (pq.size() != 0) cmp("pending reads", 36'h0, 36'(pq.size()));
		results();
	end
endmodule : dual_port_core_tb_top
